// ===== verilog/ept_pkg.sv
package ept_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_CH = 8;
    localparam int NUM_PAIR = 4;
    localparam int CH_W = 8;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_POLARITY = 8'h04;
    localparam logic [7:0] OFS_CENTER = 8'h08;
    localparam logic [7:0] OFS_JOIN = 8'h0C;
    localparam logic [7:0] OFS_PCM = 8'h10;
    localparam logic [7:0] OFS_OUTPUT = 8'h14;
    localparam logic [7:0] OFS_PERIOD = 8'h20;
    localparam logic [7:0] OFS_DUTY = 8'h40;
    localparam logic [7:0] OFS_COUNT = 8'h60;
    // Each array holds one word per channel; bits [7:5] select the array.
    localparam logic [2:0] ARR_PERIOD = 3'h1;
    localparam logic [2:0] ARR_DUTY = 3'h2;
    localparam logic [2:0] ARR_COUNT = 3'h3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'hFF;
    localparam logic [7:0] RST_CENTER = 8'h00;
    localparam logic [3:0] RST_JOIN = 4'h0;
    localparam logic [7:0] RST_PCM = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_DUTY = 8'h00;

    // ****************************************************************
    // Bus responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ept_pkg

// ===== verilog/ept_pwm_timer.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Functional notes
// [R01] Eight 8-bit channels, own counter, period, duty.
// [R02] Independent waveforms, duty zero to full.
// [R03] Selectable PCM density mode per channel.
// [R04] Per-channel programmable output polarity.
// [R05] Per-channel left or center alignment.
// [R06] Adjacent pairs join into one 16-bit channel.
// [R07] Any mix of joined and single channels.
// [R08] Counter restarts at period; output toggles at duty.
module ept_pwm_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Modulator outputs
    output logic [7:0] pwm_o
);

    // ****************************************************************
    // Configuration state
    // ****************************************************************
    logic [7:0] enable;
    logic [7:0] polarity;
    logic [7:0] center;
    logic [3:0] join_pair;
    logic [7:0] pcm;
    logic [7:0] period [8];
    logic [7:0] duty [8];

    // ****************************************************************
    // Channel state
    // ****************************************************************
    logic [15:0] count [8];
    logic [15:0] pcm_acc [8];
    logic [7:0] count_down;
    logic [7:0] pcm_bit;

    // ****************************************************************
    // Bus state
    // ****************************************************************
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    localparam logic [2:0] ARR_PERIOD_L = ept_pkg::ARR_PERIOD;
    localparam logic [2:0] ARR_DUTY_L = ept_pkg::ARR_DUTY;
    localparam logic [2:0] ARR_COUNT_L = ept_pkg::ARR_COUNT;

    // Even channel of a joined pair is idle; its registers hold the
    // low byte of the odd channel's period and duty.
    function automatic logic ch_active(input int ch,
                                       input logic [3:0] jn);
        ch_active = !(jn[ch / 2] && ((ch % 2) == 0));
    endfunction : ch_active

    // Odd channel of a joined pair sees {odd, even} as 16 bits.
    function automatic logic [15:0] wide_val(input int ch,
                                             input logic [3:0] jn,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
        if (jn[ch / 2] && ((ch % 2) == 1)) begin
            wide_val = {hi, lo};
        end else begin
            wide_val = {8'h00, hi};
        end
    endfunction : wide_val

    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0] ws);
        merge_byte = ws[0] ? wd[7:0] : old_v;
    endfunction : merge_byte

    logic [15:0] eff_period [8];
    logic [15:0] eff_duty [8];
    logic [7:0] ch_run;

    always_comb begin
        for (int c = 0; c < 8; c++) begin
            eff_period[c] = wide_val(c, join_pair, period[c],
                                     period[c ^ 1]); // [R06]
            eff_duty[c] = wide_val(c, join_pair, duty[c],
                                   duty[c ^ 1]); // [R06]
            ch_run[c] = enable[c] && ch_active(c, join_pair); // [R07]
        end
    end

    // ****************************************************************
    // Counters
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int c = 0; c < 8; c++) begin
                count[c] <= 16'h0000;
            end
            count_down <= 8'h00;
        end else begin
            for (int c = 0; c < 8; c++) begin
                if (!ch_run[c] || eff_period[c] == 16'h0000) begin
                    count[c] <= 16'h0000; // [R01]
                    count_down[c] <= 1'b0;
                end else if (!center[c]) begin
                    count_down[c] <= 1'b0;
                    if (count[c] >= eff_period[c] - 16'h0001) begin
                        count[c] <= 16'h0000; // [R08] [R05]
                    end else begin
                        count[c] <= count[c] + 16'h0001;
                    end
                end else if (!count_down[c]) begin
                    // Up then down: total period is twice the setting.
                    if (count[c] >= eff_period[c]) begin
                        count_down[c] <= 1'b1; // [R05]
                        count[c] <= count[c] - 16'h0001;
                    end else begin
                        count[c] <= count[c] + 16'h0001;
                    end
                end else begin
                    if (count[c] == 16'h0000) begin
                        count_down[c] <= 1'b0; // [R05] [R08]
                        count[c] <= 16'h0001;
                    end else begin
                        count[c] <= count[c] - 16'h0001;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // PCM accumulators
    // ****************************************************************
    // First-order density modulation spreads the active time evenly
    // over the period, which pushes ripple to a higher frequency.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int c = 0; c < 8; c++) begin
                pcm_acc[c] <= 16'h0000;
            end
            pcm_bit <= 8'h00;
        end else begin
            for (int c = 0; c < 8; c++) begin
                if (!ch_run[c] || !pcm[c]) begin
                    pcm_acc[c] <= 16'h0000;
                    pcm_bit[c] <= 1'b0;
                end else if (eff_period[c] == 16'h0000) begin
                    pcm_bit[c] <= (eff_duty[c] != 16'h0000);
                end else if ({1'b0, pcm_acc[c]} + {1'b0, eff_duty[c]} >=
                             {1'b0, eff_period[c]}) begin
                    pcm_acc[c] <= 16'((({1'b0, pcm_acc[c]} +
                                   {1'b0, eff_duty[c]}) -
                                   {1'b0, eff_period[c]})); // [R03]
                    pcm_bit[c] <= 1'b1;
                end else begin
                    pcm_acc[c] <= pcm_acc[c] + eff_duty[c]; // [R03]
                    pcm_bit[c] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Active while count is below duty, so duty 0 never asserts and
    // duty above period, or equal to it when left-aligned, asserts continuously.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pwm_o <= ~ept_pkg::RST_POLARITY;
        end else begin
            for (int c = 0; c < 8; c++) begin
                if (!ch_run[c]) begin
                    pwm_o[c] <= ~polarity[c]; // [R04]
                end else if (pcm[c]) begin
                    pwm_o[c] <= pcm_bit[c] ~^ polarity[c]; // [R03] [R04]
                end else begin
                    pwm_o[c] <= (count[c] < eff_duty[c]) ~^
                                polarity[c]; // [R02] [R08] [R04]
                end
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic do_write;
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready_o <= 1'b1;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            aw_held <= 1'b0;
            s_axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready_o <= 1'b1;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            w_held <= 1'b0;
            s_axi_wready_o <= 1'b1;
        end
    end

    logic wr_map;
    always_comb begin
        if (aw_addr[1:0] != 2'b00) begin
            wr_map = 1'b0;
        end else if (aw_addr[7:5] == ARR_PERIOD_L ||
                     aw_addr[7:5] == ARR_DUTY_L) begin
            wr_map = 1'b1;
        end else if (aw_addr == ept_pkg::OFS_ENABLE ||
                     aw_addr == ept_pkg::OFS_POLARITY ||
                     aw_addr == ept_pkg::OFS_CENTER ||
                     aw_addr == ept_pkg::OFS_JOIN ||
                     aw_addr == ept_pkg::OFS_PCM) begin
            wr_map = 1'b1;
        end else begin
            wr_map = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= ept_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_map ? ept_pkg::RESP_OKAY
                                    : ept_pkg::RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            enable <= ept_pkg::RST_ENABLE;
            polarity <= ept_pkg::RST_POLARITY;
            center <= ept_pkg::RST_CENTER;
            join_pair <= ept_pkg::RST_JOIN;
            pcm <= ept_pkg::RST_PCM;
            for (int c = 0; c < 8; c++) begin
                period[c] <= ept_pkg::RST_PERIOD;
                duty[c] <= ept_pkg::RST_DUTY;
            end
        end else if (do_write && wr_map) begin
            if (aw_addr[7:5] == ARR_PERIOD_L) begin
                period[aw_addr[4:2]] <= merge_byte(period[aw_addr[4:2]],
                                                   w_data, w_strb); // [R01]
            end else if (aw_addr[7:5] == ARR_DUTY_L) begin
                duty[aw_addr[4:2]] <= merge_byte(duty[aw_addr[4:2]],
                                                 w_data, w_strb); // [R02]
            end else if (aw_addr == ept_pkg::OFS_ENABLE) begin
                enable <= merge_byte(enable, w_data, w_strb);
            end else if (aw_addr == ept_pkg::OFS_POLARITY) begin
                polarity <= merge_byte(polarity, w_data, w_strb); // [R04]
            end else if (aw_addr == ept_pkg::OFS_CENTER) begin
                center <= merge_byte(center, w_data, w_strb); // [R05]
            end else if (aw_addr == ept_pkg::OFS_JOIN) begin
                if (w_strb[0]) begin
                    join_pair <= w_data[3:0]; // [R06] [R07]
                end
            end else begin
                pcm <= merge_byte(pcm, w_data, w_strb); // [R03]
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    logic [31:0] rd_word;
    logic rd_map;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_map = (s_axi_araddr_i[1:0] == 2'b00);
        if (!rd_map) begin
            rd_word = 32'h0000_0000;
        end else if (s_axi_araddr_i[7:5] == ARR_PERIOD_L) begin
            rd_word = {24'h00_0000, period[s_axi_araddr_i[4:2]]};
        end else if (s_axi_araddr_i[7:5] == ARR_DUTY_L) begin
            rd_word = {24'h00_0000, duty[s_axi_araddr_i[4:2]]};
        end else if (s_axi_araddr_i[7:5] == ARR_COUNT_L) begin
            rd_word = {16'h0000, count[s_axi_araddr_i[4:2]]};
        end else if (s_axi_araddr_i == ept_pkg::OFS_ENABLE) begin
            rd_word = {24'h00_0000, enable};
        end else if (s_axi_araddr_i == ept_pkg::OFS_POLARITY) begin
            rd_word = {24'h00_0000, polarity};
        end else if (s_axi_araddr_i == ept_pkg::OFS_CENTER) begin
            rd_word = {24'h00_0000, center};
        end else if (s_axi_araddr_i == ept_pkg::OFS_JOIN) begin
            rd_word = {28'h000_0000, join_pair};
        end else if (s_axi_araddr_i == ept_pkg::OFS_PCM) begin
            rd_word = {24'h00_0000, pcm};
        end else if (s_axi_araddr_i == ept_pkg::OFS_OUTPUT) begin
            rd_word = {24'h00_0000, pwm_o};
        end else begin
            rd_map = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= ept_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= rd_map ? ept_pkg::RESP_OKAY
                                    : ept_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

endmodule : ept_pwm_timer

// ===== testbench/ept_pwm_timer_assertions.sv
`timescale 1ns/1ps
module ept_pwm_timer_chk (
    input wire logic clk_i, sys_rst_i,
    input wire logic s_axi_awvalid_i, s_axi_awready_o,
    input wire logic s_axi_wvalid_i, s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o, s_axi_bready_i,
    input wire logic s_axi_arvalid_i, s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o, s_axi_rready_i,
    input wire logic [7:0] pwm_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence seq_wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence seq_rd_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    // Both halves are held one cycle before the answer is raised.
    chk_wr_answer: assert property (seq_wr_taken |=> ##1 s_axi_bvalid_o)
        else $error("write answer late");
    chk_rd_answer: assert property (seq_rd_taken |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    chk_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i
        |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
        else $error("write channel not reopened");
    chk_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i
        |=> !s_axi_rvalid_o && s_axi_arready_o)
        else $error("read channel not reopened");
    chk_w_blocked: assert property (s_axi_bvalid_o
        |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while answer pending");
    chk_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while answer pending");
    // Reset itself is the cause here, so this one is not disabled by it.
    chk_reset_idle: assert property (disable iff (1'b0) sys_rst_i
        |=> pwm_o == 8'h00 && !s_axi_bvalid_o && !s_axi_rvalid_o)
        else $error("outputs not idle after reset");
endmodule : ept_pwm_timer_chk

bind ept_pwm_timer ept_pwm_timer_chk i_chk (.clk_i, .sys_rst_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .pwm_o);

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_i = 0, sys_rst_i = 1;
    logic [7:0] aa = 0, ra = 0, pwm;
    logic [31:0] wd = 0, rd_o;
    logic av = 0, aw_r, wv = 0, w_r, bv, br = 0, arv = 0, ar_r, rv, rr = 0;
    logic [1:0] bresp, rresp;
    logic [33:0] q_r[$];
    logic [1:0] q_b[$];
    int q_p[$];
    int n_mismatch = 0, tests_run = 0, m_ch = 0, dr;
    logic [31:0] m_cnt = 0;
    logic m_on = 0, m_prev = 0;
    always #4 clk_i = ~clk_i;
    ept_pwm_timer i_ept_pwm_timer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(aa), .s_axi_awvalid_i(av), .s_axi_awready_o(aw_r),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(w_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(br), .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(ar_r), .s_axi_rdata_o(rd_o), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .pwm_o(pwm));
    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic cmp_bus(input string nm, input logic [33:0] e,
                           input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_bus
    task automatic cmp_cnt(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value pwm_count expected %0d seen %0d", e, g);
        end
    endtask : cmp_cnt
    // The watcher pops the oldest note whenever the design answers.
    always @(posedge clk_i) begin
        if (bv && br) cmp_bus("bresp", {32'h0, q_b.pop_front()}, {32'h0, bresp});
        if (rv && rr) cmp_bus("rdata", q_r.pop_front(), {rresp, rd_o});
        if (m_on) m_cnt <= m_cnt + {31'h0, pwm[m_ch]};
        if (!m_on && m_prev) begin
            cmp_cnt(32'(q_p.pop_front()), m_cnt);
            m_cnt <= 0;
        end
        m_prev <= m_on;
    end
    // ****************************************************************
    // Bus master
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = ept_pkg::RESP_OKAY);
        int n;
        n = 0;
        q_b.push_back(r);
        @(posedge clk_i);
        aa <= a; wd <= d; av <= 1; wv <= 1; br <= 1;
        do begin
            @(posedge clk_i);
            n++;
            if (av && aw_r) av <= 0;
            if (wv && w_r) wv <= 0;
        end while (!bv && n < 200);
        br <= 0;
        if (n >= 200) n_mismatch++;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = ept_pkg::RESP_OKAY);
        int n;
        n = 0;
        q_r.push_back({r, d});
        @(posedge clk_i);
        ra <= a; arv <= 1; rr <= 1;
        do begin
            @(posedge clk_i);
            n++;
            if (arv && ar_r) arv <= 0;
        end while (!rv && n < 200);
        rr <= 0;
        if (n >= 200) n_mismatch++;
    endtask : rd
    task automatic cfg(input int ch, input logic [7:0] p, input logic [7:0] d);
        wr(8'(ept_pkg::OFS_PERIOD + 4 * ch), {24'h0, p});
        wr(8'(ept_pkg::OFS_DUTY + 4 * ch), {24'h0, d});
    endtask : cfg
    // Counts high cycles of one output over whole periods after settling.
    task automatic meas(input int ch, input int len, input int e);
        q_p.push_back(e);
        repeat (600) @(posedge clk_i);
        m_ch <= ch;
        m_on <= 1;
        repeat (len) @(posedge clk_i);
        m_on <= 0;
        repeat (2) @(posedge clk_i);
    endtask : meas
    task automatic final_report;
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        #(8 * 60000);
        n_mismatch++;
        final_report;
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        void'($urandom(32'h34d6447b));
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 0;
        rd(ept_pkg::OFS_POLARITY, 32'h0000_00FF);
        rd(ept_pkg::OFS_PERIOD, 32'h0000_00FF);
        rd(ept_pkg::OFS_OUTPUT, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000, ept_pkg::RESP_SLVERR);
        wr(8'h02, 32'h0000_0001, ept_pkg::RESP_SLVERR);
        rd(ept_pkg::OFS_ENABLE, 32'h0000_0000);
        wr(ept_pkg::OFS_CENTER, 32'hFFFF_FF55);
        rd(ept_pkg::OFS_CENTER, 32'h0000_0055);
        wr(ept_pkg::OFS_CENTER, 32'h0000_0000);
        cfg(0, 8'h04, 8'h02);
        wr(ept_pkg::OFS_ENABLE, 32'h0000_0001);
        meas(0, 16, 8);
        cfg(0, 8'h04, 8'h00);
        meas(0, 16, 0);
        cfg(0, 8'h04, 8'h05);
        meas(0, 16, 16);
        cfg(0, 8'h04, 8'h01);
        wr(ept_pkg::OFS_POLARITY, 32'h0000_00FE);
        meas(0, 16, 12);
        wr(ept_pkg::OFS_POLARITY, 32'h0000_00FF);
        wr(ept_pkg::OFS_PCM, 32'h0000_0001);
        meas(0, 16, 4);
        wr(ept_pkg::OFS_PCM, 32'h0000_0000);
        cfg(0, 8'h04, 8'h02);
        wr(ept_pkg::OFS_CENTER, 32'h0000_0001);
        meas(0, 32, 12);
        wr(ept_pkg::OFS_CENTER, 32'h0000_0000);
        dr = $urandom % 9;
        cfg(2, 8'h08, 8'(dr));
        cfg(0, 8'h00, 8'h80);
        cfg(1, 8'h01, 8'h00);
        wr(ept_pkg::OFS_JOIN, 32'h0000_0001);
        wr(ept_pkg::OFS_ENABLE, 32'h0000_0006);
        meas(1, 512, 256);
        meas(0, 64, 0);
        meas(2, 64, 8 * dr);
        final_report;
    end
endmodule : tb
